// ### rtl/fmac_regs.sv
// Fault mask and converter configuration registers behind an APB slave
// What this block does
// - A system short event raises the interrupt only while mask bit 7 is clear.
// - A system over-voltage fault raises the interrupt only while mask bit 6 is clear.
// - A source-mode bus over-voltage fault raises the interrupt only while mask bit 5 is clear.
// - A source-mode bus under-voltage fault raises the interrupt only while mask bit 4 is clear.
// - A thermal shutdown raises the interrupt only while mask bit 2 is clear; bits 1-0 read zero.
// - The mask byte at 2Dh resets to zero on reset and register reset, not on watchdog.
// - The control byte holds enable, rate, resolution, averaging and seeding at bits 7 to 2.
// - The control byte at 2Eh resets to 30h and watchdog expiry clears only its enable.
// - Rate 0 converts continuously and rate 1 runs a single pass.
// - Resolution codes 0 to 3 select 15 down to 12 effective bits.
// - Averaging 0 stores single values and 1 stores a running average.
// - Seeding 0 starts the average from the stored value, 1 from a fresh conversion.
// - The disable byte at 2Fh resets to zero, one bit per channel, bit 0 reads zero.
// - The disable byte at 30h resets to zero, four channel bits, bits 3-0 read zero.
// - Results are 16-bit two's complement, bus current positive into the device.
//
// Implementation choice: the APB register port.
`timescale 1ns/1ps
`default_nettype none
module fmac_regs (
    input wire logic clk,
    input wire logic srst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic system_short_evt,
    input wire logic system_overvolt_evt,
    input wire logic source_mode_overvolt_evt,
    input wire logic source_mode_undervolt_evt,
    input wire logic thermal_shutdown_evt,
    input wire logic watchdog_expired,
    input wire logic [15:0] sample_in,
    output logic [3:0] chan_sel_out,
    output logic conv_busy,
    output logic host_irq
);
    logic [7:0] fault_interrupt_mask_second_ff;
    logic [7:0] converter_control_ff;
    logic [7:0] converter_channel_disable_first_ff;
    logic [7:0] converter_channel_disable_second_ff;
    logic [7:0] event_status_ff;
    logic [15:0] result_ff [fmac_pkg::NUM_CHAN];
    logic [7:0] nxt_event_status;
    logic [7:0] raw_evt;
    logic [7:0] wbyte;
    logic [10:0] chan_off;
    logic [3:0] chan_sel;
    logic [3:0] wr_chan;
    logic wr_en;
    logic [15:0] wr_data;
    logic pass_done;
    logic busy;
    logic one_shot_clr;
    logic reg_rst_req;
    logic bus_wr;
    logic bus_rd;

    // Byte address of a register index
    function automatic logic [11:0] byte_addr(input logic [7:0] idx);
        byte_addr = {2'h0, idx, 2'h0};
    endfunction

    // ========================================================
    // APB decode, zero wait states
    assign bus_wr = psel && penable && pwrite;
    assign bus_rd = psel && penable && !pwrite;
    assign wbyte = pwdata[7:0];
    assign reg_rst_req = bus_wr && paddr == byte_addr(fmac_pkg::IDX_CTRL_MISC)
        && pwdata[fmac_pkg::BIT_REG_RST];

    // Channel i is result i: 2Fh bit 7 is channel 0, 30h bit 4 is channel 10
    assign chan_off = {<<{converter_channel_disable_first_ff[7:1],
                       converter_channel_disable_second_ff[7:4]}};

    // ========================================================
    // Mask register
    always_ff @(posedge clk) begin
        if (srst || reg_rst_req) begin
            fault_interrupt_mask_second_ff <= fmac_pkg::RST_FAULT_MASK_SECOND;
        end else if (bus_wr && paddr == byte_addr(fmac_pkg::IDX_FAULT_MASK_SECOND)) begin
            fault_interrupt_mask_second_ff <= wbyte & fmac_pkg::WMASK_FAULT_MASK_SECOND;
        end
    end

    // ========================================================
    // Converter control; watchdog and finished one-shot clear enable
    assign one_shot_clr = pass_done && converter_control_ff[fmac_pkg::BIT_RATE];
    always_ff @(posedge clk) begin
        if (srst || reg_rst_req) begin
            converter_control_ff <= fmac_pkg::RST_CONV_CONTROL;
        end else if (bus_wr && paddr == byte_addr(fmac_pkg::IDX_CONV_CONTROL)) begin
            converter_control_ff <= wbyte & fmac_pkg::WMASK_CONV_CONTROL;
            if (watchdog_expired) begin
                converter_control_ff[fmac_pkg::BIT_CONV_EN] <= 1'b0;
            end
        end else if (watchdog_expired || one_shot_clr) begin
            converter_control_ff[fmac_pkg::BIT_CONV_EN] <= 1'b0;
        end
    end

    // ========================================================
    // Channel disable registers
    always_ff @(posedge clk) begin
        if (srst || reg_rst_req) begin
            converter_channel_disable_first_ff <= fmac_pkg::RST_CHAN_DIS_FIRST;
            converter_channel_disable_second_ff <= fmac_pkg::RST_CHAN_DIS_SECOND;
        end else if (bus_wr) begin
            if (paddr == byte_addr(fmac_pkg::IDX_CHAN_DIS_FIRST)) begin
                converter_channel_disable_first_ff <= wbyte & fmac_pkg::WMASK_CHAN_DIS_FIRST;
            end
            if (paddr == byte_addr(fmac_pkg::IDX_CHAN_DIS_SECOND)) begin
                converter_channel_disable_second_ff <= wbyte & fmac_pkg::WMASK_CHAN_DIS_SECOND;
            end
        end
    end

    // ========================================================
    // Fault events, unmasked ones latch; write one to clear, set wins
    always_comb begin
        raw_evt = 8'h00;
        raw_evt[fmac_pkg::BIT_SYS_SHORT] = system_short_evt;
        raw_evt[fmac_pkg::BIT_SYS_OVP] = system_overvolt_evt;
        raw_evt[fmac_pkg::BIT_SRC_OVP] = source_mode_overvolt_evt;
        raw_evt[fmac_pkg::BIT_SRC_UVP] = source_mode_undervolt_evt;
        raw_evt[fmac_pkg::BIT_TSHUT] = thermal_shutdown_evt;
        nxt_event_status = event_status_ff;
        if (bus_wr && paddr == byte_addr(fmac_pkg::IDX_EVENT_STATUS)) begin
            nxt_event_status = nxt_event_status & ~wbyte;
        end
        nxt_event_status = nxt_event_status | (raw_evt & ~fault_interrupt_mask_second_ff);
    end

    always_ff @(posedge clk) begin
        if (srst || reg_rst_req) begin
            event_status_ff <= 8'h00;
            host_irq <= 1'b0;
        end else begin
            event_status_ff <= nxt_event_status;
            host_irq <= |nxt_event_status;
        end
    end

    // ========================================================
    // Result storage; untouched for skipped channels
    always_ff @(posedge clk) begin
        if (srst || reg_rst_req) begin
            for (int i = 0; i < fmac_pkg::NUM_CHAN; i++) begin
                result_ff[i] <= 16'h0000;
            end
        end else if (wr_en && !chan_off[wr_chan]) begin
            result_ff[wr_chan] <= wr_data;
        end
    end

    fmac_conv_engine u_engine (
        .clk(clk),
        .srst(srst || reg_rst_req),
        .enable(converter_control_ff[fmac_pkg::BIT_CONV_EN]),
        .one_shot(converter_control_ff[fmac_pkg::BIT_RATE]),
        .resolution(converter_control_ff[fmac_pkg::BIT_RES_HI:fmac_pkg::BIT_RES_LO]),
        .avg_en(converter_control_ff[fmac_pkg::BIT_AVG]),
        .seed_fresh(converter_control_ff[fmac_pkg::BIT_SEED]),
        .chan_off(chan_off),
        .sample_in(sample_in),
        .chan_sel(chan_sel),
        .wr_chan(wr_chan),
        .wr_en(wr_en),
        .wr_data(wr_data),
        .old_value(result_ff[chan_sel]),
        .pass_done(pass_done),
        .busy(busy)
    );

    always_ff @(posedge clk) begin
        if (srst) begin
            chan_sel_out <= 4'h0;
            conv_busy <= 1'b0;
        end else begin
            chan_sel_out <= chan_sel;
            conv_busy <= busy;
        end
    end

    // ========================================================
    // Read data, registered at setup phase
    always_ff @(posedge clk) begin
        if (srst) begin
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
            pready <= 1'b0;
        end else begin
            pready <= psel && !penable;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
            if (psel && !penable) begin
                if (paddr == byte_addr(fmac_pkg::IDX_FAULT_MASK_SECOND)) begin
                    prdata[7:0] <= fault_interrupt_mask_second_ff;
                end else if (paddr == byte_addr(fmac_pkg::IDX_CONV_CONTROL)) begin
                    prdata[7:0] <= converter_control_ff;
                end else if (paddr == byte_addr(fmac_pkg::IDX_CHAN_DIS_FIRST)) begin
                    prdata[7:0] <= converter_channel_disable_first_ff;
                end else if (paddr == byte_addr(fmac_pkg::IDX_CHAN_DIS_SECOND)) begin
                    prdata[7:0] <= converter_channel_disable_second_ff;
                end else if (paddr == byte_addr(fmac_pkg::IDX_EVENT_STATUS)) begin
                    prdata[7:0] <= event_status_ff;
                end else if (paddr == byte_addr(fmac_pkg::IDX_CTRL_MISC)) begin
                    prdata[fmac_pkg::BIT_WDOG] <= watchdog_expired;
                end else if (paddr >= byte_addr(fmac_pkg::IDX_RESULT_BASE)
                    && paddr < byte_addr(fmac_pkg::IDX_RESULT_BASE + 8'(fmac_pkg::NUM_CHAN))
                    && paddr[1:0] == 2'h0) begin
                    prdata[15:0] <= result_ff[4'(paddr[5:2] - fmac_pkg::IDX_RESULT_BASE[3:0])];
                end else begin
                    pslverr <= 1'b1;
                end
            end
        end
    end
endmodule // fmac_regs
`default_nettype wire

// ### rtl/fmac_pkg.sv
// Constants and types for the fault mask and converter configuration block
package fmac_pkg;
    // ========================================================
    // Register indices; byte address is four times the index
    localparam logic [7:0] IDX_FAULT_MASK_SECOND = 8'h2D;
    localparam logic [7:0] IDX_CONV_CONTROL = 8'h2E;
    localparam logic [7:0] IDX_CHAN_DIS_FIRST = 8'h2F;
    localparam logic [7:0] IDX_CHAN_DIS_SECOND = 8'h30;
    localparam logic [7:0] IDX_EVENT_STATUS = 8'h40;
    localparam logic [7:0] IDX_RESULT_BASE = 8'h41;
    localparam logic [7:0] IDX_CTRL_MISC = 8'h4F;
    localparam int NUM_CHAN = 11;
    localparam int ADDR_W = 12;
    // ========================================================
    // Reset values and writable masks
    localparam logic [7:0] RST_FAULT_MASK_SECOND = 8'h00;
    localparam logic [7:0] RST_CONV_CONTROL = 8'h30;
    localparam logic [7:0] RST_CHAN_DIS_FIRST = 8'h00;
    localparam logic [7:0] RST_CHAN_DIS_SECOND = 8'h00;
    localparam logic [7:0] WMASK_FAULT_MASK_SECOND = 8'hFC;
    localparam logic [7:0] WMASK_CONV_CONTROL = 8'hFF;
    localparam logic [7:0] WMASK_CHAN_DIS_FIRST = 8'hFE;
    localparam logic [7:0] WMASK_CHAN_DIS_SECOND = 8'hF0;
    // ========================================================
    // Field positions
    localparam int BIT_SYS_SHORT = 7;
    localparam int BIT_SYS_OVP = 6;
    localparam int BIT_SRC_OVP = 5;
    localparam int BIT_SRC_UVP = 4;
    localparam int BIT_TSHUT = 2;
    localparam int BIT_CONV_EN = 7;
    localparam int BIT_RATE = 6;
    localparam int BIT_RES_HI = 5;
    localparam int BIT_RES_LO = 4;
    localparam int BIT_AVG = 3;
    localparam int BIT_SEED = 2;
    localparam int BIT_REG_RST = 0;
    localparam int BIT_WDOG = 1;
    // ========================================================
    // Conversion timing: base cycles, doubled per extra resolution bit
    localparam logic [15:0] CONV_CYC_12BIT = 16'h0010;
    localparam logic [15:0] ONE_CYC = 16'h0001;
    localparam logic [3:0] LAST_CHAN = 4'hA;
    typedef enum logic [1:0] {FMAC_IDLE, FMAC_CONV, FMAC_NEXT} fmac_state_e;
endpackage

// ### rtl/fmac_conv_engine.sv
// Channel sequencer with averaging for the measurement converter
`timescale 1ns/1ps
`default_nettype none
module fmac_conv_engine (
    input wire logic clk,
    input wire logic srst,
    input wire logic enable,
    input wire logic one_shot,
    input wire logic [1:0] resolution,
    input wire logic avg_en,
    input wire logic seed_fresh,
    input wire logic [10:0] chan_off,
    input wire logic [15:0] sample_in,
    output logic [3:0] chan_sel,
    output logic [3:0] wr_chan,
    output logic wr_en,
    output logic [15:0] wr_data,
    input wire logic [15:0] old_value,
    output logic pass_done,
    output logic busy
);
    fmac_pkg::fmac_state_e state_ff;
    logic [15:0] cnt_ff;
    logic [10:0] seeded_ff;

    // Conversion time grows with resolution: code 0 is 15 bit, code 3 is 12 bit
    function automatic logic [15:0] conv_cycles(input logic [1:0] res);
        conv_cycles = fmac_pkg::CONV_CYC_12BIT << (2'h3 - res);
    endfunction

    assign busy = (state_ff != fmac_pkg::FMAC_IDLE);

    // ========================================================
    // Sequencer
    always_ff @(posedge clk) begin
        if (srst) begin
            state_ff <= fmac_pkg::FMAC_IDLE;
            cnt_ff <= 16'h0000;
            chan_sel <= 4'h0;
            pass_done <= 1'b0;
        end else begin
            pass_done <= 1'b0;
            case (state_ff)
                fmac_pkg::FMAC_IDLE: begin
                    chan_sel <= 4'h0;
                    // No restart while a finished one-shot pass clears enable
                    if (enable && !pass_done) begin
                        state_ff <= fmac_pkg::FMAC_NEXT;
                    end
                end
                fmac_pkg::FMAC_NEXT: begin
                    cnt_ff <= conv_cycles(resolution);
                    if (!enable) begin
                        state_ff <= fmac_pkg::FMAC_IDLE;
                    end else if (chan_off[chan_sel]) begin
                        if (chan_sel == fmac_pkg::LAST_CHAN) begin
                            chan_sel <= 4'h0;
                            pass_done <= 1'b1;
                            if (one_shot) begin
                                state_ff <= fmac_pkg::FMAC_IDLE;
                            end
                        end else begin
                            chan_sel <= chan_sel + 4'h1;
                        end
                    end else begin
                        state_ff <= fmac_pkg::FMAC_CONV;
                    end
                end
                fmac_pkg::FMAC_CONV: begin
                    if (!enable) begin
                        state_ff <= fmac_pkg::FMAC_IDLE;
                    end else if (cnt_ff <= fmac_pkg::ONE_CYC) begin
                        state_ff <= fmac_pkg::FMAC_NEXT;
                        if (chan_sel == fmac_pkg::LAST_CHAN) begin
                            chan_sel <= 4'h0;
                            pass_done <= 1'b1;
                            if (one_shot) begin
                                state_ff <= fmac_pkg::FMAC_IDLE;
                            end
                        end else begin
                            chan_sel <= chan_sel + 4'h1;
                        end
                    end else begin
                        cnt_ff <= cnt_ff - fmac_pkg::ONE_CYC;
                    end
                end
                default: state_ff <= fmac_pkg::FMAC_IDLE;
            endcase
        end
    end

    // ========================================================
    // Result write, single value or running average
    always_ff @(posedge clk) begin
        if (srst) begin
            wr_en <= 1'b0;
            wr_chan <= 4'h0;
            wr_data <= 16'h0000;
            seeded_ff <= 11'h000;
        end else begin
            wr_en <= 1'b0;
            if (!avg_en) begin
                seeded_ff <= 11'h000;
            end
            if (state_ff == fmac_pkg::FMAC_CONV && enable && cnt_ff <= fmac_pkg::ONE_CYC) begin
                wr_en <= 1'b1;
                wr_chan <= chan_sel;
                if (!avg_en) begin
                    wr_data <= sample_in;
                end else if (!seeded_ff[chan_sel] && seed_fresh) begin
                    wr_data <= sample_in;
                    seeded_ff[chan_sel] <= 1'b1;
                end else begin
                    // Signed mean of old and new, two's complement kept
                    wr_data <= 16'((17'($signed(old_value)) + 17'($signed(sample_in))) >>> 1);
                    seeded_ff[chan_sel] <= 1'b1;
                end
            end
        end
    end
endmodule // fmac_conv_engine
`default_nettype wire

// ### testbench/fmac_host.sv
// Host model that reaches the configuration registers over APB
`timescale 1ns/1ps
`default_nettype none
module fmac_host (
    input wire logic clk,
    input wire logic pready,
    input wire logic [31:0] prdata,
    input wire logic pslverr,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [11:0] paddr,
    output logic [31:0] pwdata
);
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
    end
    // ========================================================
    // One transfer, request held until pready is sampled high
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                        output logic [31:0] q, output logic e);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
endmodule // fmac_host
`default_nettype wire

// ### testbench/fmac_regs_chk.sv
// Port-level assertions for the register block
`timescale 1ns/1ps
`default_nettype none
module fmac_regs_chk (
    input wire logic clk,
    input wire logic srst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic system_short_evt,
    input wire logic system_overvolt_evt,
    input wire logic source_mode_overvolt_evt,
    input wire logic source_mode_undervolt_evt,
    input wire logic thermal_shutdown_evt,
    input wire logic watchdog_expired,
    input wire logic [15:0] sample_in,
    input wire logic [3:0] chan_sel_out,
    input wire logic conv_busy,
    input wire logic host_irq
);
    // ========================================================
    // Shadow of the mask byte, cleared by reset and register reset only
    logic [7:0] mask_ff;
    logic [7:0] nxt_mask;
    logic wr_acc;
    logic [4:0] evt_v;
    assign wr_acc = psel && penable && pready && pwrite;
    assign evt_v = {system_short_evt, system_overvolt_evt, source_mode_overvolt_evt,
                    source_mode_undervolt_evt, thermal_shutdown_evt};
    always_comb begin
        nxt_mask = mask_ff;
        if (wr_acc && paddr == 12'h0B4) nxt_mask = pwdata[7:0];
        if (wr_acc && paddr == 12'h13C && pwdata[0]) nxt_mask = 8'h00;
    end
    always_ff @(posedge clk) begin
        if (srst) mask_ff <= 8'h00;
        else mask_ff <= nxt_mask;
    end
    // ========================================================
    // Assertions
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);
    sequence setup_s;
        psel && !penable;
    endsequence
    sequence rd_s(logic [11:0] a);
        setup_s ##0 !pwrite && paddr == a;
    endsequence
    ready_after_setup_a: assert property (setup_s |=> pready && penable)
        else $error("pready missing after setup");
    ready_pulse_a: assert property (pready |-> psel && penable ##1 !pready)
        else $error("pready not a single access pulse");
    err_with_ready_a: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    mapped_no_err_a: assert property (setup_s ##0 paddr inside {12'h0B4, 12'h0B8, 12'h0BC,
        12'h0C0} |=> !pslverr)
        else $error("error on a mapped register");
    unmasked_irq_a: assert property (|(evt_v & ~{mask_ff[7:4], mask_ff[2]}) |-> ##[1:2] host_irq)
        else $error("unmasked event gave no interrupt");
    mask_low_zero_a: assert property (rd_s(12'h0B4) |=> (prdata & 32'hFFFFFF03) == 32'h0)
        else $error("mask byte low bits not zero");
    dis_first_zero_a: assert property (rd_s(12'h0BC) |=> (prdata & 32'hFFFFFF01) == 32'h0)
        else $error("first disable byte bit 0 not zero");
    dis_second_zero_a: assert property (rd_s(12'h0C0) |=> (prdata & 32'hFFFFFF0F) == 32'h0)
        else $error("second disable byte low nibble not zero");
    chan_in_range_a: assert property (chan_sel_out <= 4'hA)
        else $error("channel index out of range");
    reset_quiet_a: assert property (@(posedge clk) disable iff (1'b0)
        srst |=> !pready && !host_irq && !conv_busy)
        else $error("outputs active after reset");
endmodule // fmac_regs_chk
bind fmac_regs fmac_regs_chk u_fmac_regs_chk (.clk, .srst, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .system_short_evt, .system_overvolt_evt,
    .source_mode_overvolt_evt, .source_mode_undervolt_evt, .thermal_shutdown_evt,
    .watchdog_expired, .sample_in, .chan_sel_out, .conv_busy, .host_irq);
`default_nettype wire

// ### testbench/test_fmac_regs.sv
// Self-checking bench for the fault mask and converter configuration block
`timescale 1ns/1ps
`default_nettype none
module test_fmac_regs;
    logic clk, srst, psel, penable, pwrite, pready, pslverr, host_irq, conv_busy, wdog, e;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, q;
    logic [4:0] evt;
    logic [15:0] sample;
    logic [3:0] chan_sel;
    int miscompares, checked, n1, n2, n3;
    int cyc = 0;
    fmac_regs u_fmac_regs (.clk(clk), .srst(srst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .system_short_evt(evt[4]), .system_overvolt_evt(evt[3]),
        .source_mode_overvolt_evt(evt[2]), .source_mode_undervolt_evt(evt[1]),
        .thermal_shutdown_evt(evt[0]), .watchdog_expired(wdog), .sample_in(sample),
        .chan_sel_out(chan_sel), .conv_busy(conv_busy), .host_irq(host_irq));
    fmac_host u_fmac_host (.clk(clk), .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));
    // ========================================================
    // Helpers
    task automatic cmp32(input string nm, input logic [31:0] x, input logic [31:0] g);
        checked++;
        if (g !== x) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", nm, x, g);
        end
    endtask
    task automatic cmp1(input string nm, input logic x, input logic g);
        cmp32(nm, {31'h0, x}, {31'h0, g});
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask
    function automatic logic [11:0] ba(input logic [7:0] idx);
        return {2'b00, idx, 2'b00};
    endfunction
    task automatic wr(input logic [7:0] i, input logic [31:0] d);
        u_fmac_host.xfer(1'b1, ba(i), d, q, e);
    endtask
    task automatic rd(input logic [7:0] i);
        u_fmac_host.xfer(1'b0, ba(i), 32'h0, q, e);
    endtask
    task automatic pulse(input logic [4:0] v);
        evt <= v;
        tick(2);
        evt <= 5'h00;
        tick(3);
    endtask
    task automatic run_pass(input logic [31:0] ctl, input logic [15:0] s, output int n);
        sample <= s;
        wr(fmac_pkg::IDX_CONV_CONTROL, ctl);
        for (n = 0; n < 3000 && conv_busy !== 1'b1; n++) @(posedge clk);
        for (n = 0; n < 3000 && conv_busy !== 1'b0; n++) @(posedge clk);
    endtask
    task automatic give_verdict();
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    // ========================================================
    // Scenarios
    task automatic t_reset_vals(input string nm);
        rd(fmac_pkg::IDX_FAULT_MASK_SECOND);
        cmp32("mask reset", 32'h00, q);
        rd(fmac_pkg::IDX_CONV_CONTROL);
        cmp32("control reset", 32'h30, q);
        rd(fmac_pkg::IDX_CHAN_DIS_FIRST);
        cmp32("disable first reset", 32'h00, q);
        rd(fmac_pkg::IDX_CHAN_DIS_SECOND);
        cmp32("disable second reset", 32'h00, q);
        $display("test %s done", nm);
    endtask
    task automatic t_access();
        wr(fmac_pkg::IDX_FAULT_MASK_SECOND, 32'hFFFFFFFF);
        rd(fmac_pkg::IDX_FAULT_MASK_SECOND);
        cmp32("mask fields", 32'hF4, q & 32'hFFFFFFF7);
        wr(fmac_pkg::IDX_CONV_CONTROL, 32'h7F);
        rd(fmac_pkg::IDX_CONV_CONTROL);
        cmp32("control fields", 32'h7F, q);
        wr(fmac_pkg::IDX_CHAN_DIS_FIRST, 32'hFF);
        rd(fmac_pkg::IDX_CHAN_DIS_FIRST);
        cmp32("disable first", 32'hFE, q);
        wr(fmac_pkg::IDX_CHAN_DIS_SECOND, 32'hFF);
        rd(fmac_pkg::IDX_CHAN_DIS_SECOND);
        cmp32("disable second", 32'hF0, q);
        u_fmac_host.xfer(1'b0, 12'h004, 32'h0, q, e);
        cmp1("unmapped error", 1'b1, e);
        cmp32("unmapped data", 32'h0, q);
        wr(fmac_pkg::IDX_CTRL_MISC, 32'h1);
        t_reset_vals("access");
    endtask
    task automatic t_irq();
        int pos [5] = '{7, 6, 5, 4, 2};
        for (int i = 0; i < 5; i++) begin
            wr(fmac_pkg::IDX_FAULT_MASK_SECOND, 32'h0);
            pulse(5'h10 >> i);
            cmp1("irq unmasked", 1'b1, host_irq);
            wr(fmac_pkg::IDX_EVENT_STATUS, 32'hFF);
            tick(2);
            cmp1("irq cleared", 1'b0, host_irq);
            wr(fmac_pkg::IDX_FAULT_MASK_SECOND, 32'h1 << pos[i]);
            pulse(5'h10 >> i);
            cmp1("irq masked", 1'b0, host_irq);
        end
        $display("test irq done");
    endtask
    task automatic t_watchdog();
        wr(fmac_pkg::IDX_FAULT_MASK_SECOND, 32'hF4);
        wr(fmac_pkg::IDX_CONV_CONTROL, 32'hBC);
        tick(400);
        cmp1("continuous busy", 1'b1, conv_busy);
        rd(fmac_pkg::IDX_CONV_CONTROL);
        cmp32("continuous enable", 32'hBC, q);
        wdog <= 1'b1;
        tick(1);
        wdog <= 1'b0;
        rd(fmac_pkg::IDX_CONV_CONTROL);
        cmp32("watchdog control", 32'h3C, q);
        rd(fmac_pkg::IDX_FAULT_MASK_SECOND);
        cmp32("watchdog mask", 32'hF4, q);
        wr(fmac_pkg::IDX_CTRL_MISC, 32'h1);
        t_reset_vals("watchdog");
    endtask
    task automatic t_convert();
        int n0;
        wr(fmac_pkg::IDX_CHAN_DIS_FIRST, 32'h80);
        run_pass(32'hF0, 16'h0100, n3);
        rd(fmac_pkg::IDX_RESULT_BASE + 8'h1);
        cmp32("single value", 32'h0100, q);
        rd(fmac_pkg::IDX_CONV_CONTROL);
        cmp32("one shot stops", 32'h70, q);
        run_pass(32'hFC, 16'h0500, n0);
        rd(fmac_pkg::IDX_RESULT_BASE + 8'h1);
        cmp32("fresh seed", 32'h0500, q);
        run_pass(32'hE8, 16'h0300, n2);
        rd(fmac_pkg::IDX_RESULT_BASE + 8'h1);
        cmp32("running average", 32'h0400, q);
        cmp32("res 13 vs 12", 32'd160, n2 - n3);
        run_pass(32'hD0, 16'hFE0C, n1);
        cmp32("res 14 vs 13", 32'd320, n1 - n2);
        rd(fmac_pkg::IDX_RESULT_BASE + 8'h1);
        cmp32("negative result", 32'h0000FE0C, q);
        rd(fmac_pkg::IDX_RESULT_BASE);
        cmp32("skipped channel", 32'h0, q);
        $display("test convert done");
    endtask
    // ========================================================
    // Clock, timeout and main sequence
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            miscompares++;
            give_verdict();
        end
    end
    initial begin
        srst = 1'b1;
        evt = 5'h00;
        wdog = 1'b0;
        sample = 16'h0000;
        miscompares = 0;
        checked = 0;
        tick(3);
        srst <= 1'b0;
        t_reset_vals("reset");
        t_access();
        t_irq();
        t_watchdog();
        t_convert();
        give_verdict();
    end
endmodule // test_fmac_regs
`default_nettype wire
